// File: pkg/cfo_pkg.sv
package cfo_pkg;
	// lane count encoding
	localparam logic [1:0] LANES_NONE = 2'h0;
	localparam logic [1:0] LANES_1 = 2'h1;
	localparam logic [1:0] LANES_2 = 2'h2;
	localparam logic [1:0] LANES_4 = 2'h3;
	// flash address width in bytes
	localparam logic [2:0] ADDR_BYTES_NARROW = 3'h3;
	localparam logic [2:0] ADDR_BYTES_WIDE = 3'h4;
	localparam logic [1:0] REV_VALUE_RESET = 2'h0;
	localparam logic [31:0] USER_WDT_RESET = 32'h00000000;
	localparam int SYNC_WIDTH = 4;
	// async input positions in the sync vector
	localparam int SYN_OVERHEAT = 0;
	localparam int SYN_ABORT = 1;
	localparam int SYN_JTAG = 2;
	localparam int SYN_RDBK = 3;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_CONFIG,
		PH_USER
	} cfo_phase_type;

	// option set carried in the configuration image
	typedef struct packed {
		logic overheat_shutdown_en;
		logic persist_en;
		logic internal_cfg_access_port;
		logic [1:0] warm_boot_rev_value;
		logic rev_pins_hiz_ctrl;
		logic parallel_abort_en;
		logic flash_wide_addr_en;
		logic [1:0] flash_lane_count;
		logic fall_edge_en;
		logic cfg_wdt_given;
		logic [31:0] cfg_wdt_value;
		logic [31:0] user_phase_wdt_value;
	} cfo_opt_type;

	localparam cfo_opt_type OPT_RESET = '{
		overheat_shutdown_en: 1'b0,
		persist_en: 1'b0,
		internal_cfg_access_port: 1'b0,
		warm_boot_rev_value: REV_VALUE_RESET,
		rev_pins_hiz_ctrl: 1'b0,
		parallel_abort_en: 1'b1,
		flash_wide_addr_en: 1'b0,
		flash_lane_count: LANES_NONE,
		fall_edge_en: 1'b0,
		cfg_wdt_given: 1'b0,
		cfg_wdt_value: 32'h00000000,
		user_phase_wdt_value: USER_WDT_RESET
	};

	// flash-facing settings
	typedef struct packed {
		logic [2:0] addr_bytes;
		logic [1:0] lane_count;
		logic fall_edge;
	} cfo_flash_type;
endpackage : cfo_pkg

// File: rtl/cfo_top.sv
`timescale 1ns/10ps
// Behaviour
// - overheat shuts down only when enabled
// - persist keeps config pins after configuration
// - persist and internal access port exclusive
// - boundary-scan port always usable
// - parallel readback needs persist
// - two-bit revision value into warm-boot register
// - hiz control 0 floats, 1 drives pins
// - abort honoured only when abort enabled
// - wide option gives 32-bit flash addresses
// - flash read over 1, 2, 4 lanes
// - optional falling-edge flash data capture
// - config watchdog value enables and loads timer
// - user and config watchdog values exclusive
module cfo_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic opt_load,
	input wire cfo_pkg::cfo_opt_type opt_in,
	input wire logic cfg_start,
	input wire logic cfg_done,
	input wire logic reconfig,
	input wire logic warm_boot_req,
	input wire logic overheat_alarm,
	input wire logic abort_seq,
	input wire logic jtag_req,
	input wire logic rdbk_req,
	output logic opt_error,
	output cfo_pkg::cfo_phase_type phase,
	output logic shutdown,
	output logic pins_owned,
	output logic jtag_grant,
	output logic rdbk_grant,
	output logic [1:0] warm_boot_start_addr_reg,
	output logic [1:0] rev_sel_pins_o,
	output logic rev_sel_pins_oe_n,
	output logic abort_taken,
	output cfo_pkg::cfo_flash_type flash_cfg,
	output logic wdt_running,
	output logic wdt_expired
);
	cfo_pkg::cfo_opt_type opt_reg;
	cfo_pkg::cfo_phase_type phase_reg;
	logic [cfo_pkg::SYNC_WIDTH-1:0] sync1_reg;
	logic [cfo_pkg::SYNC_WIDTH-1:0] sync2_reg;
	logic [cfo_pkg::SYNC_WIDTH-1:0] sync3_reg;
	logic [cfo_pkg::SYNC_WIDTH-1:0] stable_reg;
	logic [cfo_pkg::SYNC_WIDTH-1:0] stable_prev_reg;
	logic [31:0] wdt_count_reg;
	logic opt_conflict;
	logic abort_edge;

	assign phase = phase_reg;
	// image must never ask for both of a pair
	assign opt_conflict = (opt_in.persist_en & opt_in.internal_cfg_access_port)
		| (opt_in.cfg_wdt_given & (opt_in.user_phase_wdt_value != 32'h00000000));
	assign abort_edge = stable_reg[cfo_pkg::SYN_ABORT] & ~stable_prev_reg[cfo_pkg::SYN_ABORT];

	// three stages; a level counts once stages two and three agree
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			stable_reg <= '0;
			stable_prev_reg <= '0;
		end else if (ce) begin
			sync1_reg <= {rdbk_req, jtag_req, abort_seq, overheat_alarm};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			for (int i = 0; i < cfo_pkg::SYNC_WIDTH; i++) begin
				if (sync2_reg[i] == sync3_reg[i]) begin
					stable_reg[i] <= sync3_reg[i];
				end
			end
			stable_prev_reg <= stable_reg;
		end
	end

	// options taken only while idle, so they never change mid-phase
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			opt_reg <= cfo_pkg::OPT_RESET;
			opt_error <= 1'b0;
		end else if (ce) begin
			if (opt_load && phase_reg == cfo_pkg::PH_IDLE) begin
				if (opt_conflict) begin
					opt_error <= 1'b1;
				end else begin
					opt_reg <= opt_in;
					opt_error <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phase_reg <= cfo_pkg::PH_IDLE;
		end else if (ce) begin
			case (phase_reg)
				cfo_pkg::PH_IDLE: begin
					if (cfg_start && !opt_error && !opt_load) begin
						phase_reg <= cfo_pkg::PH_CONFIG;
					end
				end
				cfo_pkg::PH_CONFIG: begin
					if (abort_edge && opt_reg.parallel_abort_en) begin
						phase_reg <= cfo_pkg::PH_IDLE;
					end else if (wdt_expired) begin
						phase_reg <= cfo_pkg::PH_IDLE;
					end else if (cfg_done) begin
						phase_reg <= cfo_pkg::PH_USER;
					end
				end
				cfo_pkg::PH_USER: begin
					if (reconfig) begin
						phase_reg <= cfo_pkg::PH_IDLE;
					end
				end
				default: begin
					phase_reg <= cfo_pkg::PH_IDLE;
				end
			endcase
		end
	end

	// abort is only a report here; the phase machine acts on it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			abort_taken <= 1'b0;
		end else if (ce) begin
			abort_taken <= abort_edge && opt_reg.parallel_abort_en
				&& phase_reg == cfo_pkg::PH_CONFIG;
		end
	end

	// shutdown is sticky until reset: power is gone anyway
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			shutdown <= 1'b0;
		end else if (ce) begin
			if (stable_reg[cfo_pkg::SYN_OVERHEAT] && opt_reg.overheat_shutdown_en) begin
				shutdown <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pins_owned <= 1'b0;
			jtag_grant <= 1'b0;
			rdbk_grant <= 1'b0;
		end else if (ce) begin
			pins_owned <= phase_reg == cfo_pkg::PH_CONFIG
				|| (phase_reg == cfo_pkg::PH_USER && opt_reg.persist_en);
			jtag_grant <= stable_reg[cfo_pkg::SYN_JTAG];
			rdbk_grant <= stable_reg[cfo_pkg::SYN_RDBK] && opt_reg.persist_en
				&& phase_reg == cfo_pkg::PH_USER;
		end
	end

	// warm-boot register loads at the end of configuration
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			warm_boot_start_addr_reg <= cfo_pkg::REV_VALUE_RESET;
			rev_sel_pins_o <= cfo_pkg::REV_VALUE_RESET;
			rev_sel_pins_oe_n <= 1'b1;
		end else if (ce) begin
			if (phase_reg == cfo_pkg::PH_CONFIG && cfg_done) begin
				warm_boot_start_addr_reg <= opt_reg.warm_boot_rev_value;
			end
			if (warm_boot_req && phase_reg == cfo_pkg::PH_USER) begin
				rev_sel_pins_o <= warm_boot_start_addr_reg;
				rev_sel_pins_oe_n <= ~opt_reg.rev_pins_hiz_ctrl;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flash_cfg <= '{addr_bytes: cfo_pkg::ADDR_BYTES_NARROW,
				lane_count: cfo_pkg::LANES_NONE, fall_edge: 1'b0};
		end else if (ce) begin
			flash_cfg.addr_bytes <= opt_reg.flash_wide_addr_en
				? cfo_pkg::ADDR_BYTES_WIDE : cfo_pkg::ADDR_BYTES_NARROW;
			flash_cfg.lane_count <= opt_reg.flash_lane_count;
			flash_cfg.fall_edge <= opt_reg.fall_edge_en;
		end
	end

	// config timer counts down from the image value; user timer likewise
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wdt_count_reg <= '0;
			wdt_running <= 1'b0;
			wdt_expired <= 1'b0;
		end else if (ce) begin
			wdt_expired <= 1'b0;
			if (phase_reg == cfo_pkg::PH_IDLE && cfg_start && !opt_error && !opt_load) begin
				wdt_count_reg <= opt_reg.cfg_wdt_value;
				wdt_running <= opt_reg.cfg_wdt_given;
			end else if (phase_reg == cfo_pkg::PH_CONFIG && cfg_done) begin
				wdt_count_reg <= opt_reg.user_phase_wdt_value;
				wdt_running <= opt_reg.user_phase_wdt_value != 32'h00000000;
			end else if (phase_reg == cfo_pkg::PH_IDLE) begin
				wdt_running <= 1'b0;
			end else if (wdt_running) begin
				if (wdt_count_reg == 32'h00000000) begin
					wdt_expired <= 1'b1;
					wdt_running <= 1'b0;
				end else begin
					wdt_count_reg <= wdt_count_reg - 32'h00000001;
				end
			end
		end
	end

	chk_conflict_rejected: assert property (@(posedge mclk) disable iff (rst)
		ce && opt_load && opt_conflict && phase_reg == cfo_pkg::PH_IDLE
		|=> opt_error && $stable(opt_reg))
		else $error("conflicting options were accepted");

	chk_opts_held: assert property (@(posedge mclk) disable iff (rst)
		phase_reg != cfo_pkg::PH_IDLE |=> $stable(opt_reg))
		else $error("options changed outside idle");

	chk_shutdown_gate: assert property (@(posedge mclk) disable iff (rst)
		$rose(shutdown) |-> $past(opt_reg.overheat_shutdown_en)
		&& $past(stable_reg[cfo_pkg::SYN_OVERHEAT]))
		else $error("shutdown without enabled overheat");

	chk_pins_released: assert property (@(posedge mclk) disable iff (rst)
		ce && phase_reg == cfo_pkg::PH_USER && !opt_reg.persist_en
		|=> !pins_owned)
		else $error("pins kept without persist");

	chk_jtag_follow: assert property (@(posedge mclk) disable iff (rst)
		ce && stable_reg[cfo_pkg::SYN_JTAG] |=> jtag_grant)
		else $error("jtag request not granted");

	chk_rdbk_persist: assert property (@(posedge mclk) disable iff (rst)
		rdbk_grant |-> opt_reg.persist_en)
		else $error("readback granted without persist");

	chk_rev_drive: assert property (@(posedge mclk) disable iff (rst)
		ce && warm_boot_req && phase_reg == cfo_pkg::PH_USER
		|=> rev_sel_pins_oe_n == !opt_reg.rev_pins_hiz_ctrl
		&& rev_sel_pins_o == $past(warm_boot_start_addr_reg))
		else $error("revision pins wrong after warm boot");

	chk_abort_ignored: assert property (@(posedge mclk) disable iff (rst)
		ce && phase_reg == cfo_pkg::PH_CONFIG && !opt_reg.parallel_abort_en
		&& abort_edge && !cfg_done && !wdt_expired |=> phase_reg == cfo_pkg::PH_CONFIG)
		else $error("disabled abort took effect");

	chk_addr_width: assert property (@(posedge mclk) disable iff (rst)
		ce && opt_reg.flash_wide_addr_en ##1 ce && $stable(opt_reg)
		|=> flash_cfg.addr_bytes == cfo_pkg::ADDR_BYTES_WIDE)
		else $error("wide address not applied");

	chk_wdt_expiry: assert property (@(posedge mclk) disable iff (rst)
		wdt_expired |-> $past(wdt_count_reg) == 32'h00000000 && !wdt_running)
		else $error("watchdog expired early");
endmodule : cfo_top

// File: sim/cfo_host_model.sv
`timescale 1ns/10ps
module cfo_host_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] want,
	output logic overheat_alarm,
	output logic abort_seq,
	output logic jtag_req,
	output logic rdbk_req
);
	// pins move only just after an edge, as a board-level source would
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			overheat_alarm <= 1'b0;
			abort_seq <= 1'b0;
			jtag_req <= 1'b0;
			rdbk_req <= 1'b0;
		end else begin
			overheat_alarm <= want[cfo_pkg::SYN_OVERHEAT];
			abort_seq <= want[cfo_pkg::SYN_ABORT];
			jtag_req <= want[cfo_pkg::SYN_JTAG];
			rdbk_req <= want[cfo_pkg::SYN_RDBK];
		end
	end
endmodule : cfo_host_model

// File: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	localparam int K_START = 0;
	localparam int K_DONE = 1;
	localparam int K_RECFG = 2;
	localparam int K_WARM = 3;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic opt_load = 1'b0;
	logic [3:0] ctl = 4'h0;
	logic [3:0] want = 4'h0;
	cfo_pkg::cfo_opt_type opt_in = cfo_pkg::OPT_RESET;
	cfo_pkg::cfo_opt_type o;
	cfo_pkg::cfo_phase_type phase;
	cfo_pkg::cfo_flash_type flash_cfg;
	logic overheat_alarm, abort_seq, jtag_req, rdbk_req, opt_error, shutdown, pins_owned;
	logic jtag_grant, rdbk_grant, rev_sel_pins_oe_n, abort_taken, wdt_running, wdt_expired;
	logic [1:0] warm_boot_start_addr_reg;
	logic [1:0] rev_sel_pins_o;
	int errors = 0;
	int tests_run = 0;
	int n;
	int aborts = 0;
	logic [95:0] rnd;
	always #2.5 mclk = ~mclk;
	// one-cycle report, so it is counted at the falling edge where it stands
	always @(negedge mclk) begin
		if (abort_taken === 1'b1) aborts++;
	end
	cfo_top cfo_top_inst (.mclk, .rst, .ce, .opt_load, .opt_in, .cfg_start(ctl[K_START]),
		.cfg_done(ctl[K_DONE]), .reconfig(ctl[K_RECFG]), .warm_boot_req(ctl[K_WARM]),
		.overheat_alarm, .abort_seq, .jtag_req, .rdbk_req, .opt_error, .phase, .shutdown,
		.pins_owned, .jtag_grant, .rdbk_grant, .warm_boot_start_addr_reg, .rev_sel_pins_o,
		.rev_sel_pins_oe_n, .abort_taken, .flash_cfg, .wdt_running, .wdt_expired);
	cfo_host_model cfo_host_model_inst (.mclk, .rst, .want, .overheat_alarm, .abort_seq,
		.jtag_req, .rdbk_req);
	function automatic cfo_pkg::cfo_flash_type exp_flash(input cfo_pkg::cfo_opt_type v);
		exp_flash.addr_bytes = v.flash_wide_addr_en ? cfo_pkg::ADDR_BYTES_WIDE
			: cfo_pkg::ADDR_BYTES_NARROW;
		exp_flash.lane_count = v.flash_lane_count;
		exp_flash.fall_edge = v.fall_edge_en;
	endfunction : exp_flash
	task automatic check(input logic [39:0] seen, input logic [39:0] expd);
		tests_run++;
		if (seen !== expd) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expd);
		end
	endtask : check
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic pulse(input int k);
		@(posedge mclk) ctl[k] <= 1'b1;
		@(posedge mclk) ctl[k] <= 1'b0;
		#1;
	endtask : pulse
	task automatic load(input cfo_pkg::cfo_opt_type v);
		@(posedge mclk);
		opt_in <= v;
		opt_load <= 1'b1;
		@(posedge mclk) opt_load <= 1'b0;
		#1;
	endtask : load
	task automatic pins(input logic [3:0] w);
		@(posedge mclk) want <= w;
		cyc(8);
	endtask : pins
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#30000;
		errors++;
		report_and_stop;
	end
	initial begin
		void'($urandom(95308));
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		cyc(1);
		check(phase, cfo_pkg::PH_IDLE);
		check(flash_cfg, exp_flash(cfo_pkg::OPT_RESET));
		check(rev_sel_pins_oe_n, 1'b1);
		check(warm_boot_start_addr_reg, cfo_pkg::REV_VALUE_RESET);
		$display("test reset ended");
		o = cfo_pkg::OPT_RESET;
		o.persist_en = 1'b1;
		o.internal_cfg_access_port = 1'b1;
		load(o);
		check(opt_error, 1'b1);
		o = cfo_pkg::OPT_RESET;
		o.cfg_wdt_given = 1'b1;
		o.user_phase_wdt_value = 32'h00000001;
		load(o);
		check(opt_error, 1'b1);
		pulse(K_START);
		check(phase, cfo_pkg::PH_IDLE);
		$display("test conflicts ended");
		for (int i = 0; i < 8; i++) begin
			rnd = {$urandom, $urandom, $urandom};
			o = rnd[$bits(cfo_pkg::cfo_opt_type)-1:0];
			o.internal_cfg_access_port = o.internal_cfg_access_port & ~o.persist_en;
			o.cfg_wdt_given = 1'b0;
			o.flash_lane_count = i[1:0];
			o.parallel_abort_en = i[2];
			load(o);
			check(opt_error, 1'b0);
			cyc(1);
			check(flash_cfg, exp_flash(o));
			pulse(K_START);
			check(wdt_running, 1'b0);
			cyc(1);
			check(pins_owned, 1'b1);
			n = aborts;
			pins(4'h2);
			check(phase, o.parallel_abort_en ? cfo_pkg::PH_IDLE : cfo_pkg::PH_CONFIG);
			check(aborts - n, o.parallel_abort_en);
			pins(4'h0);
			if (o.parallel_abort_en) pulse(K_START);
			pulse(K_DONE);
			check(phase, cfo_pkg::PH_USER);
			check(warm_boot_start_addr_reg, o.warm_boot_rev_value);
			cyc(1);
			check(pins_owned, o.persist_en);
			pulse(K_WARM);
			check(rev_sel_pins_o, o.warm_boot_rev_value);
			check(rev_sel_pins_oe_n, !o.rev_pins_hiz_ctrl);
			pins(4'hc);
			check(jtag_grant, 1'b1);
			check(rdbk_grant, o.persist_en);
			pins(4'h0);
			check(jtag_grant, 1'b0);
			load(~o);
			cyc(1);
			check(flash_cfg, exp_flash(o));
			pulse(K_RECFG);
			check(phase, cfo_pkg::PH_IDLE);
		end
		$display("test random option sets ended");
		o = cfo_pkg::OPT_RESET;
		o.cfg_wdt_given = 1'b1;
		o.cfg_wdt_value = 32'h00000006;
		load(o);
		cyc(1);
		pulse(K_START);
		check(wdt_running, 1'b1);
		n = 0;
		// clock enable low for three of the cycles: the count must freeze
		while (wdt_expired !== 1'b1 && n < 40) begin
			@(posedge mclk) ce <= n >= 3;
			#1;
			n++;
		end
		check(n, 6 + 1 + 3);
		cyc(2);
		check(phase, cfo_pkg::PH_IDLE);
		$display("test watchdog ended");
		load(cfo_pkg::OPT_RESET);
		pins(4'h1);
		check(shutdown, 1'b0);
		pins(4'h0);
		o = cfo_pkg::OPT_RESET;
		o.overheat_shutdown_en = 1'b1;
		load(o);
		pins(4'h1);
		check(shutdown, 1'b1);
		$display("test overheat ended");
		report_and_stop;
	end
endmodule : tb_top
